// File: design/bridge_pkg.sv
// Constants and carrier types for the serial-to-printer bridge.
// Assumes one 20 MHz clock; all timing is counted in its cycles.
package bridge_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int BAUD_RATE = 2400;
   localparam int BIT_CYC_DEF = CLK_HZ / BAUD_RATE;
   localparam int WD_CYC_DEF = 2 * BIT_CYC_DEF;
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam int FRAME_BITS = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FLOW_MARGIN = 4;
   localparam int SETUP_NS = 1000;
   localparam int STROBE_NS = 1000;
   localparam int HOLD_NS = 1000;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [BYTE_W-1:0] CR_CODE = 8'h0d;
   localparam logic [BYTE_W-1:0] LF_CODE = 8'h0a;
   localparam logic [BYTE_W-1:0] IDLE_DATA = 8'hff;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_START = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } rx_state_t;

   typedef enum logic [1:0] {
      PRN_IDLE = 2'h0,
      PRN_SETUP = 2'h1,
      PRN_STROBE = 2'h3,
      PRN_HOLD = 2'h2
   } prn_state_t;

   typedef struct packed {
      logic valid;
      logic [BYTE_W-1:0] data;
   } byte_beat_t;
endpackage : bridge_pkg

// File: design/serial_to_printer_bridge.sv
// Serial receiver, line buffer and printer port driver.
// Assumes serialIn and printerBusy are already synchronous to clk.
// Summary of operation
// (RL1) Serial characters arrive at 2400 baud, no parity, eight data bits, one stop bit.
// (RL2) Received text is held until a carriage return (13) has been received or the buffer is full.
// (RL3) The host sends a line feed (10) after each line so the printer advances a row.
// (RL4) The block drives the printer strobe itself and watches printer busy.
// (RL5) The printer side is eight data outputs, a strobe output and a busy input.
// (RL6) A flow-control output offers hardware handshaking to a PC host.
// (RL7) All timing, bit sampling included, is derived from the single clock.
// (RL8) A watchdog returns stalled control logic to idle.
// (RL9) Every received character goes to the data outputs unchanged as one byte; characters arriving at a full buffer are dropped.
// (RL10) A flow-controlled host ties its clear-to-send and data-set-ready to the flow output.
// (RL11) While idle the data outputs and the strobe stay high.
// (RL12) Each byte waits for busy low and stays stable around the low strobe pulse.
// (RL13) Flow control drops whenever further characters cannot be accepted.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_ff;
   logic [AW:0] rdPtr_ff;
   logic doWrite;
   logic doRead;

   assign level = wrPtr_ff - rdPtr_ff;
   assign inReady = level != (AW+1)'(DEPTH);
   assign outValid = level != '0;
   assign outData = mem[rdPtr_ff[AW-1:0]];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr_ff[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
      end else begin
         if (doWrite) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (doRead) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
      end
   end
endmodule : byte_fifo

////////////////////////////////////////////////////////////////////////////////
module serial_to_printer_bridge
   import bridge_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYC_DEF,
   parameter int WD_CYC = WD_CYC_DEF,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serialIn,
   output logic flowReady,
   output logic [BYTE_W-1:0] printerData,
   output logic printerStrobeN,
   input wire logic printerBusy
);
   localparam int LW = $clog2(DEPTH) + 1;

   function automatic logic atLast(input logic [CNT_W-1:0] cnt, input int lim);
      atLast = cnt == CNT_W'(lim - 1);
   endfunction : atLast

   rx_state_t rxState_ff;
   prn_state_t prnState_ff;
   logic [CNT_W-1:0] rxCnt_ff;
   logic [2:0] rxIdx_ff;
   logic [BYTE_W-1:0] rxShift_ff;
   byte_beat_t rxBeat;
   logic [CNT_W-1:0] prnCnt_ff;
   logic [BYTE_W-1:0] printerData_ff;
   logic printerStrobeN_ff;
   logic [CNT_W-1:0] wdCnt_ff;
   logic wdBite;
   logic [LW-1:0] crCount_ff;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [BYTE_W-1:0] fifoOutData;
   logic [LW-1:0] fifoLevel;
   logic releaseLine;
   logic rxBitEnd;

   ////////////////////////////////////////////////////////////////////////////
   // Serial receiver
   assign rxBitEnd = (rxState_ff == RX_START) ? atLast(rxCnt_ff, BIT_CYC / 2)
                                              : atLast(rxCnt_ff, BIT_CYC);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxState_ff <= RX_IDLE;
         rxCnt_ff <= '0;
         rxIdx_ff <= '0;
         rxShift_ff <= '0;
      end else if (wdBite) begin
         rxState_ff <= RX_IDLE; // [RL8]
         rxCnt_ff <= '0;
      end else begin
         rxCnt_ff <= (rxState_ff == RX_IDLE || rxBitEnd) ? '0 : rxCnt_ff + 1'b1; // [RL7]
         unique case (rxState_ff)
            RX_IDLE: begin
               if (!serialIn) begin
                  rxState_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rxBitEnd) begin
                  rxState_ff <= serialIn ? RX_IDLE : RX_DATA;
                  rxIdx_ff <= '0;
               end
            end
            RX_DATA: begin
               if (rxBitEnd) begin
                  rxShift_ff <= {serialIn, rxShift_ff[BYTE_W-1:1]}; // [RL1]
                  rxIdx_ff <= rxIdx_ff + 1'b1;
                  if (rxIdx_ff == 3'(FRAME_BITS - 1)) begin
                     rxState_ff <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rxBitEnd) begin
                  rxState_ff <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // Frame accepted only with a high stop bit
   assign rxBeat.valid = !wdBite && rxState_ff == RX_STOP && rxBitEnd && serialIn; // [RL1]
   assign rxBeat.data = rxShift_ff; // [RL9]

   ////////////////////////////////////////////////////////////////////////////
   // Line buffer
   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk), .rst_n(rst_n), .inValid(rxBeat.valid), .inReady(fifoInReady),
      .inData(rxBeat.data), .outValid(fifoOutValid), .outReady(fifoOutReady),
      .outData(fifoOutData), .level(fifoLevel)
   );

   // Count of carriage returns held; a full buffer also releases
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crCount_ff <= '0;
      end else begin
         crCount_ff <= crCount_ff
            + LW'(rxBeat.valid && fifoInReady && rxBeat.data == CR_CODE)
            - LW'(fifoOutValid && fifoOutReady && fifoOutData == CR_CODE); // [RL2]
      end
   end

   assign releaseLine = crCount_ff != '0 || !fifoInReady; // [RL2]
   assign fifoOutReady = prnState_ff == PRN_IDLE && releaseLine && !printerBusy && !wdBite;
   assign flowReady = fifoLevel < LW'(DEPTH - FLOW_MARGIN); // [RL6] [RL13]

   ////////////////////////////////////////////////////////////////////////////
   // Printer port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prnState_ff <= PRN_IDLE;
         prnCnt_ff <= '0;
         printerData_ff <= IDLE_DATA;
         printerStrobeN_ff <= 1'b1;
      end else if (wdBite) begin
         prnState_ff <= PRN_IDLE; // [RL8]
         prnCnt_ff <= '0;
         printerData_ff <= IDLE_DATA;
         printerStrobeN_ff <= 1'b1;
      end else begin
         prnCnt_ff <= prnCnt_ff + 1'b1;
         unique case (prnState_ff)
            PRN_IDLE: begin
               prnCnt_ff <= '0;
               if (fifoOutValid && fifoOutReady) begin
                  prnState_ff <= PRN_SETUP; // [RL12]
                  printerData_ff <= fifoOutData; // [RL9]
               end
            end
            PRN_SETUP: begin
               if (atLast(prnCnt_ff, SETUP_CYC)) begin
                  prnState_ff <= PRN_STROBE;
                  prnCnt_ff <= '0;
                  printerStrobeN_ff <= 1'b0; // [RL4]
               end
            end
            PRN_STROBE: begin
               if (atLast(prnCnt_ff, STROBE_CYC)) begin
                  prnState_ff <= PRN_HOLD;
                  prnCnt_ff <= '0;
                  printerStrobeN_ff <= 1'b1;
               end
            end
            PRN_HOLD: begin
               if (atLast(prnCnt_ff, HOLD_CYC)) begin
                  prnState_ff <= PRN_IDLE;
                  printerData_ff <= IDLE_DATA; // [RL11]
               end
            end
         endcase
      end
   end

   assign printerData = printerData_ff; // [RL5]
   assign printerStrobeN = printerStrobeN_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdCnt_ff <= '0;
      end else if (wdBite || rxBitEnd || (rxState_ff == RX_IDLE && prnState_ff == PRN_IDLE)) begin
         wdCnt_ff <= '0;
      end else begin
         wdCnt_ff <= wdCnt_ff + 1'b1; // [RL8]
      end
   end

   assign wdBite = atLast(wdCnt_ff, WD_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_busy_wait;
      @(posedge clk) disable iff (!rst_n)
      $rose(prnState_ff == PRN_SETUP) |-> $past(!printerBusy);
   endproperty
   a_busy_wait: assert property (p_busy_wait) else $error("byte started while busy"); // [RL12]
   property p_data_stable;
      @(posedge clk) disable iff (!rst_n)
      !printerStrobeN |-> $stable(printerData) && $past(printerData) == printerData_ff;
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved in strobe"); // [RL12]
   property p_idle_high;
      @(posedge clk) disable iff (!rst_n)
      prnState_ff == PRN_IDLE |-> printerData == IDLE_DATA && printerStrobeN;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle lines not high"); // [RL11]
   property p_strobe_width;
      @(posedge clk) disable iff (!rst_n || wdBite)
      $fell(printerStrobeN) |-> !printerStrobeN [*8];
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // [RL4]
   property p_hold_line;
      @(posedge clk) disable iff (!rst_n)
      $rose(prnState_ff == PRN_SETUP) |-> $past(crCount_ff != '0 || !fifoInReady);
   endproperty
   a_hold_line: assert property (p_hold_line) else $error("printed before return"); // [RL2]
   property p_flow;
      @(posedge clk) disable iff (!rst_n)
      !fifoInReady |-> !flowReady;
   endproperty
   a_flow: assert property (p_flow) else $error("flow high while full"); // [RL13]
   property p_watchdog;
      @(posedge clk) disable iff (!rst_n)
      wdBite |=> rxState_ff == RX_IDLE && prnState_ff == PRN_IDLE && wdCnt_ff == '0;
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog did not recover"); // [RL8]
   property p_byte_pass;
      @(posedge clk) disable iff (!rst_n || wdBite)
      fifoOutValid && fifoOutReady |=> printerData == $past(fifoOutData);
   endproperty
   a_byte_pass: assert property (p_byte_pass) else $error("byte altered"); // [RL9]
   property p_frame;
      @(posedge clk) disable iff (!rst_n)
      rxBeat.valid |-> rxState_ff == RX_STOP && rxCnt_ff == CNT_W'(BIT_CYC - 1);
   endproperty
   a_frame: assert property (p_frame) else $error("byte outside stop bit"); // [RL1] [RL7]
endmodule : serial_to_printer_bridge

// File: test/printer_model.sv
// Printer model: records each strobed byte and raises busy after it.
// Assumes an active-low strobe and a bench that drives stall.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module printer_model #(
   parameter int BUSY_CYC = 60
) (
   input wire logic clk,
   input wire logic [7:0] printerData,
   input wire logic printerStrobeN,
   input wire logic stall,
   output logic printerBusy
);
   logic [7:0] got[$];
   logic [7:0] held = 8'h00;
   logic strobeNPrev = 1'b1;
   int busyCnt = 0;
   int badCount = 0;
   initial printerBusy = 1'b0;
   // Capture on strobe fall, hold busy afterwards and while stalled
   always @(negedge clk) begin
      if (strobeNPrev === 1'b1 && printerStrobeN === 1'b0) begin
         held = printerData;
         got.push_back(printerData);
         busyCnt = BUSY_CYC;
      end else if (busyCnt > 0) begin
         busyCnt = busyCnt - 1;
      end
      // Data must not move while strobe is low or as it rises
      if ((printerStrobeN !== 1'b1 || strobeNPrev !== 1'b1) && printerData !== held) begin
         badCount = badCount + 1;
      end
      strobeNPrev = printerStrobeN;
      printerBusy = stall || busyCnt > 0;
   end
endmodule : printer_model

// File: test/tb_top.sv
// Bench for the serial-to-printer bridge with a printer model.
// Assumes a shortened bit time; inputs change on the falling edge.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_top
   import bridge_pkg::*;
;
   localparam int BIT = 16;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic serialIn = 1'b1;
   logic stall = 1'b0;
   logic flowReady;
   logic [BYTE_W-1:0] printerData;
   logic printerStrobeN;
   logic printerBusy;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;

   always #25 clk = ~clk;

   serial_to_printer_bridge #(.BIT_CYC(BIT), .WD_CYC(200), .DEPTH(16)) dut_u (
      .clk(clk), .rst_n(rst_n), .serialIn(serialIn), .flowReady(flowReady),
      .printerData(printerData), .printerStrobeN(printerStrobeN),
      .printerBusy(printerBusy));

   printer_model #(.BUSY_CYC(60)) prn_u (
      .clk(clk), .printerData(printerData), .printerStrobeN(printerStrobeN),
      .stall(stall), .printerBusy(printerBusy));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // Cycle ceiling
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         end_of_test();
      end
   end

   // One frame, LSB first, then one idle bit time
   task automatic sendByte(input logic [7:0] b, input logic stopBit);
      logic [9:0] frame;
      frame = {stopBit, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         serialIn = frame[i];
         repeat (BIT - 1) @(negedge clk);
      end
      serialIn = 1'b1;
      repeat (BIT) @(negedge clk);
   endtask : sendByte

   task automatic expectPrinted(input logic [7:0] exp[$]);
      for (int i = 0; i < 6000 && prn_u.got.size() < exp.size(); i++) @(negedge clk);
      repeat (100) @(negedge clk);
      check("count", 8'(prn_u.got.size()), 8'(exp.size()));
      foreach (exp[i]) begin
         if (i < prn_u.got.size()) check("byte", prn_u.got[i], exp[i]);
      end
      prn_u.got.delete();
   endtask : expectPrinted

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("data idle", printerData, IDLE_DATA);
      check("strobe idle", 8'(printerStrobeN), 8'h01);
      check("flow", 8'(flowReady), 8'h01);
   endtask : t_reset

   task automatic t_hold();
      sendByte(8'h48, 1'b1);
      sendByte(8'h69, 1'b1);
      repeat (200) @(negedge clk);
      check("held count", 8'(prn_u.got.size()), 8'h00);
      check("data idle", printerData, IDLE_DATA);
      sendByte(LF_CODE, 1'b1);
      sendByte(CR_CODE, 1'b1);
      expectPrinted('{8'h48, 8'h69, 8'h0a, 8'h0d});
   endtask : t_hold

   task automatic t_codes();
      logic [7:0] codes[$];
      codes = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'h0d};
      foreach (codes[i]) sendByte(codes[i], 1'b1);
      expectPrinted(codes);
   endtask : t_codes

   task automatic t_bad_stop();
      sendByte(8'h41, 1'b0);
      sendByte(8'h42, 1'b1);
      sendByte(CR_CODE, 1'b1);
      expectPrinted('{8'h42, 8'h0d});
   endtask : t_bad_stop

   task automatic t_busy_flow();
      logic [7:0] exp[$];
      stall = 1'b1;
      for (int i = 0; i < 12; i++) begin
         exp.push_back(i == 11 ? CR_CODE : 8'(8'h30 + i));
         check("flow send", 8'(flowReady), 8'h01);
         sendByte(exp[i], 1'b1);
         if (i == 10) check("flow below", 8'(flowReady), 8'h01);
      end
      check("flow full", 8'(flowReady), 8'h00);
      check("busy count", 8'(prn_u.got.size()), 8'h00);
      stall = 1'b0;
      expectPrinted(exp);
      check("flow after", 8'(flowReady), 8'h01);
      check("stable", 8'(prn_u.badCount), 8'h00);
   endtask : t_busy_flow

   // Host without flow control overruns a stalled printer
   task automatic t_overrun();
      logic [7:0] exp[$];
      stall = 1'b1;
      for (int i = 0; i < 17; i++) begin
         sendByte(8'(8'h61 + i), 1'b1);
         if (i < 16) exp.push_back(8'(8'h61 + i));
      end
      check("flow overrun", 8'(flowReady), 8'h00);
      check("full count", 8'(prn_u.got.size()), 8'h00);
      stall = 1'b0;
      repeat (200) @(negedge clk);
      check("full release", 8'(prn_u.got.size()), 8'h01);
      sendByte(CR_CODE, 1'b1);
      exp.push_back(CR_CODE);
      expectPrinted(exp);
   endtask : t_overrun

   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_hold();
      t_codes();
      t_bad_stop();
      t_busy_flow();
      t_overrun();
      end_of_test();
   end
endmodule : tb_top
